// file: hdl/udsr_pkg.sv
// Package with register map, field positions and encodings for the user/subcode/status bank
package udsr_pkg;
   localparam logic [6:0] ADDR_USER_CTRL = 7'h13;
   localparam logic [6:0] ADDR_SUBCODE_FIRST = 7'h14;
   localparam logic [6:0] ADDR_SUBCODE_LAST = 7'h1D;
   localparam logic [6:0] ADDR_RATE_RATIO = 7'h1E;
   localparam logic [6:0] ADDR_WINDOW_FIRST = 7'h20;
   localparam logic [6:0] ADDR_WINDOW_LAST = 7'h37;
   localparam logic [6:0] ADDR_IDENTITY = 7'h7F;
   localparam int WINDOW_BYTES = 24;
   localparam int SUBCODE_BYTES = 10;
   localparam int SUBCODE_BITS = 80;
   localparam int BIT_USER_E_TO_F_INHIBIT = 0;
   localparam int BIT_USER_D_TO_E_INHIBIT = 1;
   localparam int BIT_MODE_LO = 2;
   localparam int BIT_DIR = 4;
   localparam logic [7:0] USER_CTRL_MASK = 8'h1F;
   localparam logic [7:0] USER_CTRL_RESET = 8'h00;
   localparam logic [7:0] CS_CTRL_RESET = 8'h00;
   localparam int BIT_BUFFER_WINDOW_SELECT = 5;
   localparam logic [1:0] MODE_ZEROS = 2'h0;
   localparam logic [1:0] MODE_BLOCK = 2'h1;
   localparam logic [1:0] MODE_RESERVED = 2'h2;
   localparam logic [1:0] MODE_CONSUMER_B = 2'h3;
   localparam logic [4:0] WINDOW_BASE_IDX = 5'h00;
endpackage

// file: hdl/udsr_regs.sv
// Register bank for user-bit control, subcode, rate ratio, identity and buffer E window
//
// Contract
// - Direction 0 makes the user pin an input sampled on both output frame clock edges, source of tx U data.
// - Direction 1 drives the user pin with received bits on both input frame clock edges; tx U data from buffer.
// - Manager mode 00 sends zeros, 01 is block mode, 11 is consumer mode B, 10 is reserved.
// - D-to-E inhibit set blocks D-to-E user transfers, only in block mode.
// - E-to-F inhibit set blocks E-to-F user transfers, only in block mode.
// - Ten read-only subcode bytes hold the 80-bit Q subcode in documented field order.
// - Each subcode byte carries its earliest bit in bit 7, so Q[79] lands in bit 0 of the tenth byte.
// - A read-only byte reports the rate ratio, two integer bits above six fraction bits.
// - Addresses 20h to 37h reach buffer E, channel status or user data, user only in block mode.
// - A read-only register holds identity code in the upper nibble and revision in the lower.
// - Buffer-select 0 puts channel status in the window, 1 puts user data there in block mode and channel status otherwise.
`timescale 1ns/1ns
module udsr_regs #(
   parameter logic [3:0] DEVICE_ID = 4'hA, // Arbitrary value
   parameter logic [3:0] REVISION = 4'h5 // Arbitrary value
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [6:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   input wire logic cs_ctrl_wr_i,
   input wire logic [7:0] cs_ctrl_wdata_i,
   input wire logic [79:0] subcode_q_i,
   input wire logic subcode_valid_i,
   input wire logic [7:0] rate_ratio_value_i,
   input wire logic output_frame_clock_i,
   input wire logic input_frame_clock_i,
   input wire logic user_pin_in_i,
   input wire logic rx_user_bit_i,
   input wire logic [7:0] user_buf_tx_i,
   output logic user_pin_out_o,
   output logic user_pin_oe_o,
   output logic tx_user_bit_o,
   output logic [1:0] user_bit_manager_mode_o,
   output logic user_d_to_e_allow_o,
   output logic user_e_to_f_allow_o,
   output logic buffer_window_select_o,
   output logic [4:0] win_idx_o,
   output logic cs_win_wr_o,
   output logic user_win_wr_o,
   output logic [7:0] win_wdata_o,
   input wire logic [7:0] cs_win_rdata_i,
   input wire logic [7:0] user_win_rdata_i
);
   typedef struct packed {
      logic user_pin_direction;
      logic [1:0] user_bit_manager_mode;
      logic user_d_to_e_inhibit;
      logic user_e_to_f_inhibit;
      logic buffer_window_select;
      logic [79:0] subcode;
      logic [7:0] rate_ratio;
      logic ofc_d;
      logic ifc_d;
      logic pin_out;
      logic pin_oe;
      logic tx_bit;
      logic d_to_e_allow;
      logic e_to_f_allow;
      logic [4:0] win_idx;
      logic cs_wr;
      logic user_wr;
      logic [7:0] win_wdata;
      logic [7:0] rdata;
   } udsr_state_s;

   udsr_state_s st;
   udsr_state_s next_st;

   function automatic logic in_range(input logic [6:0] a, input logic [6:0] lo,
                                     input logic [6:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [7:0] subcode_byte(input logic [79:0] q, input logic [3:0] n);
      logic [7:0] b;
      b = 8'h00;
      for (int k = 0; k < 8; k++) begin
         b[7 - k] = q[n * 8 + k];
      end
      subcode_byte = b;
   endfunction

   logic block_mode;
   logic user_win;
   logic win_hit;
   logic [3:0] sub_idx;
   logic [4:0] win_off;

   always_comb begin
      block_mode = (st.user_bit_manager_mode == udsr_pkg::MODE_BLOCK);
      user_win = st.buffer_window_select && block_mode;
      win_hit = in_range(addr_i, udsr_pkg::ADDR_WINDOW_FIRST, udsr_pkg::ADDR_WINDOW_LAST);
      sub_idx = 4'(addr_i - udsr_pkg::ADDR_SUBCODE_FIRST);
      win_off = 5'(addr_i - udsr_pkg::ADDR_WINDOW_FIRST);
      next_st = st;
      next_st.cs_wr = 1'b0;
      next_st.user_wr = 1'b0;
      if (wr_i && addr_i == udsr_pkg::ADDR_USER_CTRL) begin
         next_st.user_pin_direction = wdata_i[udsr_pkg::BIT_DIR];
         if (wdata_i[udsr_pkg::BIT_MODE_LO +: 2] != udsr_pkg::MODE_RESERVED) begin
            next_st.user_bit_manager_mode = wdata_i[udsr_pkg::BIT_MODE_LO +: 2];
         end
         next_st.user_d_to_e_inhibit = wdata_i[udsr_pkg::BIT_USER_D_TO_E_INHIBIT];
         next_st.user_e_to_f_inhibit = wdata_i[udsr_pkg::BIT_USER_E_TO_F_INHIBIT];
      end
      if (cs_ctrl_wr_i) begin
         next_st.buffer_window_select = cs_ctrl_wdata_i[udsr_pkg::BIT_BUFFER_WINDOW_SELECT];
      end
      if (wr_i && win_hit) begin
         next_st.win_idx = win_off;
         next_st.win_wdata = wdata_i;
         next_st.cs_wr = !user_win;
         next_st.user_wr = user_win;
      end else if (rd_i && win_hit) begin
         next_st.win_idx = win_off;
      end
      if (subcode_valid_i) begin
         next_st.subcode = subcode_q_i;
      end
      next_st.rate_ratio = rate_ratio_value_i;
      // Frame clock edge tracking for the user pin
      next_st.ofc_d = output_frame_clock_i;
      next_st.ifc_d = input_frame_clock_i;
      // Output enable follows the direction bit in the cycle it is written
      next_st.pin_oe = next_st.user_pin_direction;
      if (st.user_pin_direction) begin
         if (st.ifc_d != input_frame_clock_i) begin
            next_st.pin_out = rx_user_bit_i;
         end
      end else begin
         next_st.pin_out = 1'b0;
      end
      unique case (st.user_bit_manager_mode)
         udsr_pkg::MODE_ZEROS: next_st.tx_bit = 1'b0;
         default: begin
            if (st.user_pin_direction) begin
               next_st.tx_bit = user_buf_tx_i[0];
            end else if (st.ofc_d != output_frame_clock_i) begin
               next_st.tx_bit = user_pin_in_i;
            end
         end
      endcase
      next_st.d_to_e_allow = !(block_mode && st.user_d_to_e_inhibit);
      next_st.e_to_f_allow = !(block_mode && st.user_e_to_f_inhibit);
      next_st.rdata = 8'h00;
      if (rd_i) begin
         if (addr_i == udsr_pkg::ADDR_USER_CTRL) begin
            next_st.rdata = {3'h0, st.user_pin_direction, st.user_bit_manager_mode,
                             st.user_d_to_e_inhibit, st.user_e_to_f_inhibit};
         end else if (in_range(addr_i, udsr_pkg::ADDR_SUBCODE_FIRST,
                               udsr_pkg::ADDR_SUBCODE_LAST)) begin
            next_st.rdata = subcode_byte(st.subcode, sub_idx);
         end else if (addr_i == udsr_pkg::ADDR_RATE_RATIO) begin
            next_st.rdata = st.rate_ratio;
         end else if (addr_i == udsr_pkg::ADDR_IDENTITY) begin
            next_st.rdata = {DEVICE_ID, REVISION};
         end else if (win_hit) begin
            next_st.rdata = user_win ? user_win_rdata_i : cs_win_rdata_i;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         st <= '0;
         st.d_to_e_allow <= 1'b1;
         st.e_to_f_allow <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign user_pin_out_o = st.pin_out;
   assign user_pin_oe_o = st.pin_oe;
   assign tx_user_bit_o = st.tx_bit;
   assign user_bit_manager_mode_o = st.user_bit_manager_mode;
   assign user_d_to_e_allow_o = st.d_to_e_allow;
   assign user_e_to_f_allow_o = st.e_to_f_allow;
   assign buffer_window_select_o = st.buffer_window_select;
   assign win_idx_o = st.win_idx;
   assign cs_win_wr_o = st.cs_wr;
   assign user_win_wr_o = st.user_wr;
   assign win_wdata_o = st.win_wdata;
endmodule

// file: tb/udsr_regs_asserts.sv
// Checker for the user/subcode/status register bank
`timescale 1ns/1ns
module udsr_regs_asserts #(
   parameter logic [3:0] DEVICE_ID = 4'hA,
   parameter logic [3:0] REVISION = 4'h5
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [6:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   input wire logic user_pin_oe_o,
   input wire logic [1:0] user_bit_manager_mode_o,
   input wire logic user_d_to_e_allow_o,
   input wire logic user_e_to_f_allow_o,
   input wire logic buffer_window_select_o,
   input wire logic [4:0] win_idx_o,
   input wire logic cs_win_wr_o
);
   logic w13;
   assign w13 = wr_i && addr_i == 7'h13 && wdata_i[3:2] != 2'h2;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_id; rd_i && addr_i == 7'h7F |=> rdata_o == {DEVICE_ID, REVISION}; endproperty
   a_id: assert property (p_id) else $error("identity read wrong");
   property p_ctrl; rd_i && addr_i == 7'h13 |=> rdata_o[7:5] == 3'h0; endproperty
   a_ctrl: assert property (p_ctrl) else $error("unused control bits set");
   property p_mode; w13 |=> user_bit_manager_mode_o == $past(wdata_i[3:2]); endproperty
   a_mode: assert property (p_mode) else $error("mode not taken");
   property p_resv; wr_i && addr_i == 7'h13 && wdata_i[3:2] == 2'h2 |=>
      $stable(user_bit_manager_mode_o); endproperty
   a_resv: assert property (p_resv) else $error("reserved mode taken");
   property p_dir; w13 |=> user_pin_oe_o == $past(wdata_i[4]); endproperty
   a_dir: assert property (p_dir) else $error("pin direction wrong");
   property p_allow; user_bit_manager_mode_o != 2'h1 |=>
      user_d_to_e_allow_o && user_e_to_f_allow_o; endproperty
   a_allow: assert property (p_allow) else $error("inhibit outside block mode");
   property p_inh; w13 && wdata_i[3:2] == 2'h1 |=> ##1
      {user_d_to_e_allow_o, user_e_to_f_allow_o} == ~$past(wdata_i[1:0], 2); endproperty
   a_inh: assert property (p_inh) else $error("inhibit levels wrong");
   property p_win; wr_i && addr_i inside {[7'h20:7'h37]} && !buffer_window_select_o |=>
      cs_win_wr_o && win_idx_o == $past(addr_i[4:0]); endproperty
   a_win: assert property (p_win) else $error("window write wrong");
endmodule
bind udsr_regs udsr_regs_asserts #(.DEVICE_ID(DEVICE_ID), .REVISION(REVISION)) chk_inst (.*);

// file: tb/udsr_far_model.sv
// Far-side model: frame clocks, user bit sources and the measured rate ratio
`timescale 1ns/1ns
module udsr_far_model (
   input wire logic mclk_i,
   output logic ofc_o,
   output logic ifc_o,
   output logic pin_o,
   output logic rx_o,
   output logic [7:0] rate_o
);
   logic [3:0] cnt = 4'h0;
   always @(posedge mclk_i) cnt <= cnt + 4'h1;
   assign ofc_o = cnt[3];
   assign ifc_o = cnt[2];
   assign pin_o = cnt[1];
   assign rx_o = ~cnt[0];
   assign rate_o = 8'h5A;
endmodule

// file: tb/udsr_regs_test.sv
// Self-checking bench for the user/subcode/status register bank
`timescale 1ns/1ns
module udsr_regs_test;
   logic mclk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, cs_ctrl_wr_i = 0, subcode_valid_i = 0;
   logic [6:0] addr_i = 7'h00;
   logic [7:0] wdata_i = 8'h00, cs_ctrl_wdata_i = 8'h00, user_buf_tx_i = 8'h01, v, e;
   logic [7:0] cs_win_rdata_i = 8'h5A, user_win_rdata_i = 8'hC3, rdata_o, win_wdata_o;
   logic [7:0] rate_ratio_value_i;
   logic [79:0] subcode_q_i = 80'h0;
   logic output_frame_clock_i, input_frame_clock_i, user_pin_in_i, rx_user_bit_i;
   logic user_pin_out_o, user_pin_oe_o, tx_user_bit_o, user_d_to_e_allow_o;
   logic user_e_to_f_allow_o, buffer_window_select_o, cs_win_wr_o, user_win_wr_o;
   logic [1:0] user_bit_manager_mode_o;
   logic [4:0] win_idx_o;
   int n_fail = 0, cmp_count = 0;
   always #5 mclk_i = ~mclk_i;
   udsr_regs #(.DEVICE_ID(4'h6), .REVISION(4'h9)) udsr_regs_inst (.*);
   udsr_far_model udsr_far_model_inst (.mclk_i(mclk_i), .ofc_o(output_frame_clock_i),
      .ifc_o(input_frame_clock_i), .pin_o(user_pin_in_i), .rx_o(rx_user_bit_i),
      .rate_o(rate_ratio_value_i));
   task chk(input string s, input logic [7:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", s, exp, got);
      end
   endtask
   task wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task rdc(input string s, input logic [6:0] a, input logic [7:0] x);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 chk(s, rdata_o, x);
   endtask
   task stop_test;
      if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge mclk_i);
      rstn_i <= 1'b1;
      rdc("ctrl", 7'h13, 8'h00);
      rdc("ident", 7'h7F, 8'h69);
      rdc("unmapped", 7'h1F, 8'h00);
      wr(7'h13, 8'hFF);
      chk("oe", {7'h00, user_pin_oe_o}, 8'h01);
      rdc("ctrl", 7'h13, 8'h1F);
      chk("allow", {6'h00, user_d_to_e_allow_o, user_e_to_f_allow_o}, 8'h03);
      // Model drives the received bit high at every input frame clock change
      repeat (6) @(posedge mclk_i);
      #1 chk("pinout", {7'h00, user_pin_out_o}, 8'h01);
      chk("txbuf", {7'h00, tx_user_bit_o}, 8'h01);
      wr(7'h13, 8'h08);
      chk("resv", {6'h00, user_bit_manager_mode_o}, 8'h03);
      wr(7'h13, 8'h07);
      @(posedge mclk_i);
      #1 chk("inh", {6'h00, user_d_to_e_allow_o, user_e_to_f_allow_o}, 8'h00);
      rdc("ctrl", 7'h13, 8'h07);
      wr(7'h25, 8'hA5);
      chk("cswr", {cs_win_wr_o, user_win_wr_o, 1'b0, win_idx_o}, 8'h85);
      chk("wdata", win_wdata_o, 8'hA5);
      cs_ctrl_wr_i <= 1'b1;
      cs_ctrl_wdata_i <= 8'h20;
      @(posedge mclk_i);
      cs_ctrl_wr_i <= 1'b0;
      wr(7'h37, 8'h3C);
      chk("uwr", {cs_win_wr_o, user_win_wr_o, 1'b0, win_idx_o}, 8'h57);
      rdc("uwin", 7'h20, 8'hC3);
      // Input pin is low at every output frame clock change in the model
      chk("txpin", {5'h00, tx_user_bit_o, user_pin_oe_o, user_pin_out_o}, 8'h00);
      wr(7'h13, 8'h00);
      rdc("cswin", 7'h20, 8'h5A);
      repeat (20) @(posedge mclk_i);
      #1 chk("txz", {6'h00, tx_user_bit_o, user_pin_oe_o}, 8'h00);
      subcode_q_i <= 80'h0123_4567_89AB_CDEF_1357;
      subcode_valid_i <= 1'b1;
      @(posedge mclk_i);
      subcode_valid_i <= 1'b0;
      for (int n = 0; n < 10; n++) begin
         for (int k = 0; k < 8; k++) e[7 - k] = subcode_q_i[8 * n + k];
         rdc("subcode", 7'h14 + 7'(n), e);
      end
      rdc("rate", 7'h1E, 8'h5A);
      stop_test();
   end
endmodule
